/* hw/pwr_mode_pkg.sv */
// Package: constants, states and carriers for the reader power mode controller
package pwr_mode_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int CLKOUT_NORMAL_HZ = 5_000_000;
    localparam int CLKOUT_LOW_HZ = 60_000;
    // Half periods of the clock output, rounded down
    localparam int HALF_NORMAL = CLK_HZ / (2 * CLKOUT_NORMAL_HZ);
    localparam int HALF_LOW = CLK_HZ / (2 * CLKOUT_LOW_HZ);
    localparam int WAKE_WINDOW_US = 200;
    localparam int WAKE_WINDOW_CYC = WAKE_WINDOW_US * (CLK_HZ / 1_000_000);
    localparam int OSC_SETTLE_US = 100;
    localparam int OSC_SETTLE_CYC = OSC_SETTLE_US * (CLK_HZ / 1_000_000);
    localparam int CNT_W = 16;
    localparam int DIV_W = 10;
    // ------------------------------------------------------------
    // Host FIFO
    // ------------------------------------------------------------
    localparam int FIFO_DEPTH = 24;
    localparam int DATA_W = 8;
    localparam int PTR_W = 5;
    // ------------------------------------------------------------
    // Configuration preset
    // ------------------------------------------------------------
    localparam logic [7:0] CFG_PRESET = 8'h00;

    typedef enum logic [2:0] {
        ST_DOWN, ST_SETTLE, ST_NORMAL, ST_STANDBY, ST_WAKE_SETTLE, ST_WAKE
    } pwr_state_t;

    // Analog enables driven to the front end
    typedef struct packed {
        logic reg_on;
        logic reg_low_power;
        logic ref_on;
        logic xosc_on;
        logic xosc_low_power;
        logic rfosc_on;
        logic pll_on;
        logic tx_on;
        logic rx_on;
        logic vdd_d_low_power;
    } pwr_enables_t;

    // Host side configuration bits
    typedef struct packed {
        logic standby_req;
        logic field_enable_bit;
        logic direct_mode;
        logic clock_out_drain_select;
        logic [7:0] cfg;
    } host_cfg_t;

    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] data;
    } byte_t;
endpackage

/* hw/reader_power_mode_control.sv */
// Reader power mode controller with clock output and shared host FIFO
`timescale 1ns/1ps
module reader_power_mode_control
    import pwr_mode_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_enable_pin,
    input wire logic i_wake_mode_pin,
    input wire logic i_wake_strap,
    input wire logic i_serial_strap,
    input wire host_cfg_t i_host_cfg,
    input wire logic i_cfg_wr,
    input wire byte_t i_host_byte,
    input wire logic i_host_is_tx,
    input wire logic i_proto_take,
    input wire byte_t i_rx_byte,
    input wire logic i_host_take,
    output logic o_system_clock_output,
    output logic o_clkout_oe,
    output pwr_enables_t o_enables,
    output logic o_ready,
    output logic o_field_on,
    output logic o_direct_mode,
    output logic o_serial_mode,
    output logic [7:0] o_cfg,
    output byte_t o_fifo_out,
    output logic o_fifo_full,
    output logic o_fifo_empty,
    output logic o_host_irq
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        pwr_state_t st;
        logic [CNT_W-1:0] cnt;
        logic [DIV_W-1:0] div;
        logic clk_lvl;
        logic wake_prev;
        logic [3:0] cfg_bits;
        logic [7:0] cfg;
        logic [PTR_W-1:0] wp;
        logic [PTR_W-1:0] rp;
        logic [PTR_W:0] fill;
        logic clk_out;
        logic clk_oe;
        pwr_enables_t en;
        logic ready;
        byte_t out;
        logic irq;
        logic serial;
        logic full;
        logic empty;
    } state_t;

    state_t s_r, s_nxt;
    logic [DATA_W-1:0] mem_r [FIFO_DEPTH];
    logic push, pop;
    logic [DIV_W-1:0] half;
    logic clk_run, in_normal, src_host;

    // FIFO shared by both directions; host writes TX bytes, protocol writes RX bytes
    // Direct mode keeps host bytes out without letting RX bytes in on the TX side
    assign src_host = i_host_is_tx;
    assign push = (src_host ? i_host_byte.valid && !s_r.cfg_bits[1]
        : i_rx_byte.valid) && s_r.fill != 6'(FIFO_DEPTH) && in_normal;
    assign pop = (i_host_is_tx ? i_proto_take : i_host_take) && s_r.fill != '0;
    assign in_normal = s_r.st == ST_NORMAL;

    always_ff @(posedge i_clk_sys) begin
        if (push) begin
            mem_r[s_r.wp] <= src_host ? i_host_byte.data : i_rx_byte.data;
        end
    end

    // Next state logic
    always_comb begin
        s_nxt = s_r;
        s_nxt.wake_prev = i_wake_mode_pin;
        if (s_r.cnt != '0) begin
            s_nxt.cnt = s_r.cnt - 1'b1;
        end
        // Configuration writes, kept in every mode except power down
        if (i_cfg_wr && s_r.st != ST_DOWN) begin
            s_nxt.cfg_bits = {i_host_cfg.standby_req, i_host_cfg.field_enable_bit,
                              i_host_cfg.direct_mode, i_host_cfg.clock_out_drain_select};
            s_nxt.cfg = i_host_cfg.cfg;
        end
        case (s_r.st)
            ST_DOWN: begin
                s_nxt.cfg_bits = '0;
                s_nxt.cfg = CFG_PRESET;
                if (i_enable_pin) begin
                    s_nxt.st = ST_SETTLE;
                    s_nxt.cnt = CNT_W'(OSC_SETTLE_CYC);
                end else if (s_r.wake_prev && !i_wake_mode_pin) begin
                    s_nxt.st = ST_WAKE_SETTLE;
                    s_nxt.cnt = CNT_W'(OSC_SETTLE_CYC);
                end
            end
            ST_SETTLE: begin
                if (!i_enable_pin) begin
                    s_nxt.st = ST_DOWN;
                end else if (s_r.cnt == '0) begin
                    s_nxt.st = ST_NORMAL;
                end
            end
            ST_NORMAL: begin
                if (!i_enable_pin) begin
                    s_nxt.st = ST_DOWN;
                end else if (s_r.cfg_bits[3]) begin
                    s_nxt.st = ST_STANDBY;
                end
            end
            ST_STANDBY: begin
                if (!i_enable_pin) begin
                    s_nxt.st = ST_DOWN;
                end else if (!s_r.cfg_bits[3]) begin
                    s_nxt.st = ST_NORMAL;
                end
            end
            ST_WAKE_SETTLE: begin
                if (i_enable_pin) begin
                    s_nxt.st = ST_SETTLE;
                end else if (s_r.cnt == '0) begin
                    s_nxt.st = ST_WAKE;
                    s_nxt.cnt = CNT_W'(WAKE_WINDOW_CYC);
                end
            end
            ST_WAKE: begin
                if (i_enable_pin) begin
                    s_nxt.st = ST_NORMAL;
                end else if (s_r.cnt == '0) begin
                    s_nxt.st = ST_DOWN;
                end
            end
            default: s_nxt.st = ST_DOWN;
        endcase
        if (!i_enable_pin && s_nxt.st != ST_WAKE_SETTLE && s_nxt.st != ST_WAKE) begin
            s_nxt.st = ST_DOWN;
        end
        // Analog enables per mode
        s_nxt.en = '0;
        case (s_nxt.st)
            ST_SETTLE, ST_NORMAL, ST_WAKE_SETTLE, ST_WAKE: begin
                s_nxt.en.reg_on = 1'b1;
                s_nxt.en.ref_on = 1'b1;
                s_nxt.en.xosc_on = 1'b1;
                s_nxt.en.rfosc_on = 1'b1;
                s_nxt.en.pll_on = 1'b1;
                s_nxt.en.tx_on = s_nxt.st == ST_NORMAL && s_nxt.cfg_bits[2];
                s_nxt.en.rx_on = s_nxt.st == ST_NORMAL && s_nxt.cfg_bits[2];
            end
            ST_STANDBY: begin
                s_nxt.en.reg_on = 1'b1;
                s_nxt.en.reg_low_power = 1'b1;
                s_nxt.en.ref_on = 1'b1;
                s_nxt.en.xosc_on = 1'b1;
                s_nxt.en.xosc_low_power = 1'b1;
            end
            default: begin
                s_nxt.en.vdd_d_low_power = i_wake_strap;
            end
        endcase
        s_nxt.ready = s_nxt.st == ST_NORMAL;
        // Clock output divider
        // Follows the next state, so no edge leaks into a settling phase
        clk_run = s_nxt.st == ST_NORMAL || s_nxt.st == ST_STANDBY || s_nxt.st == ST_WAKE
            || (s_nxt.st == ST_DOWN && i_wake_strap);
        half = (s_nxt.st == ST_DOWN) ? DIV_W'(HALF_LOW) : DIV_W'(HALF_NORMAL);
        if (!clk_run) begin
            s_nxt.div = '0;
            s_nxt.clk_lvl = 1'b0;
        end else if (s_r.div >= half - 1'b1) begin
            s_nxt.div = '0;
            s_nxt.clk_lvl = ~s_r.clk_lvl;
        end else begin
            s_nxt.div = s_r.div + 1'b1;
        end
        // Open drain: drive only low, release for high
        if (s_r.cfg_bits[0]) begin
            s_nxt.clk_out = 1'b0;
            s_nxt.clk_oe = ~s_nxt.clk_lvl;
        end else begin
            s_nxt.clk_out = s_nxt.clk_lvl;
            s_nxt.clk_oe = 1'b1;
        end
        // FIFO pointers
        if (push) begin
            s_nxt.wp = (s_r.wp == PTR_W'(FIFO_DEPTH - 1)) ? '0 : s_r.wp + 1'b1;
        end
        if (pop) begin
            s_nxt.rp = (s_r.rp == PTR_W'(FIFO_DEPTH - 1)) ? '0 : s_r.rp + 1'b1;
        end
        s_nxt.fill = s_r.fill + {5'b0, push} - {5'b0, pop};
        s_nxt.out.valid = pop;
        s_nxt.out.data = pop ? mem_r[s_r.rp] : s_r.out.data;
        s_nxt.irq = !i_host_is_tx && s_nxt.fill != '0;
        if (s_nxt.st == ST_DOWN) begin
            s_nxt.wp = '0;
            s_nxt.rp = '0;
            s_nxt.fill = '0;
            s_nxt.irq = 1'b0;
        end
        // Flags and strap registered for the outputs
        s_nxt.full = s_nxt.fill == 6'(FIFO_DEPTH);
        s_nxt.empty = s_nxt.fill == '0;
        s_nxt.serial = i_serial_strap;
    end

    // State register
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            s_r <= '{st: ST_DOWN, cfg: CFG_PRESET, wake_prev: 1'b1, empty: 1'b1, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign o_system_clock_output = s_r.clk_out;
    assign o_clkout_oe = s_r.clk_oe;
    assign o_enables = s_r.en;
    assign o_ready = s_r.ready;
    assign o_field_on = s_r.cfg_bits[2];
    assign o_direct_mode = s_r.cfg_bits[1];
    assign o_serial_mode = s_r.serial;
    assign o_cfg = s_r.cfg;
    assign o_fifo_out = s_r.out;
    assign o_fifo_full = s_r.full;
    assign o_fifo_empty = s_r.empty;
    assign o_host_irq = s_r.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_DOWN_DISABLED: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        s_r.st == ST_DOWN |-> !s_r.en.pll_on && !s_r.en.reg_on && !s_r.ready)
        else $error("functions on in power down");
    AST_ENABLE_WAKES: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        s_r.st == ST_DOWN && i_enable_pin |=> s_r.en.xosc_on && s_r.en.pll_on)
        else $error("enable did not start supplies");
    AST_CLK_AFTER_SETTLE: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (s_r.st == ST_SETTLE || s_r.st == ST_WAKE_SETTLE) |-> !s_r.ready && !s_r.clk_lvl)
        else $error("clock before settle");
    AST_STANDBY_OFF: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        s_r.st == ST_STANDBY |-> !s_r.en.pll_on && !s_r.en.tx_on && s_r.en.xosc_low_power)
        else $error("standby enables wrong");
    AST_CFG_KEPT: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        s_r.st == ST_STANDBY && !i_cfg_wr ##1 s_r.st == ST_NORMAL |-> $stable(s_r.cfg))
        else $error("config lost over standby");
    AST_LOW_CLK: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        s_r.st == ST_DOWN && i_wake_strap && s_r.div == '0 && $past(s_r.st) == ST_DOWN
        && $past(s_r.div) != '0 |-> s_r.clk_lvl != $past(s_r.clk_lvl))
        else $error("low clock divider wrong");
    AST_WAKE_END: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        s_r.st == ST_WAKE && s_r.cnt == '0 && !i_enable_pin |=> s_r.st == ST_DOWN)
        else $error("wake window not closed");
    AST_FORCE_DOWN: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        (s_r.st == ST_NORMAL || s_r.st == ST_STANDBY) && !i_enable_pin |=> s_r.st == ST_DOWN)
        else $error("enable low ignored");
    AST_FIFO_BOUND: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        s_r.fill <= 6'(FIFO_DEPTH))
        else $error("fifo overflow");
    AST_OPEN_DRAIN: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        $past(s_r.cfg_bits[0]) |-> !s_r.clk_out)
        else $error("open drain drove high");
endmodule // reader_power_mode_control

/* sim/host_model.sv */
// Host controller model driving enable, wake pin, configuration and TX bytes
`timescale 1ns/1ps
module host_model
    import pwr_mode_pkg::*;
(
    input wire logic i_clk_sys,
    output logic o_enable_pin,
    output logic o_wake_mode_pin,
    output host_cfg_t o_host_cfg,
    output logic o_cfg_wr,
    output byte_t o_host_byte
);
    // Idle levels at time zero
    initial begin
        o_enable_pin = 1'b0;
        o_wake_mode_pin = 1'b1;
        o_host_cfg = '0;
        o_cfg_wr = 1'b0;
        o_host_byte = '0;
    end
    // Enable level, raised inside the wake window to keep normal mode
    task automatic set_enable(input logic lvl);
        @(negedge i_clk_sys);
        o_enable_pin = lvl;
    endtask
    // Short low pulse on the wake pin
    task automatic wake_pulse();
        @(negedge i_clk_sys);
        o_wake_mode_pin = 1'b0;
        repeat (3) @(negedge i_clk_sys);
        o_wake_mode_pin = 1'b1;
    endtask
    // One-cycle configuration write, every field taken from the argument
    task automatic write_cfg(input host_cfg_t c);
        @(negedge i_clk_sys);
        o_host_cfg = c;
        o_cfg_wr = 1'b1;
        @(negedge i_clk_sys);
        o_cfg_wr = 1'b0;
    endtask
    // One byte on the 8-bit port; data shows its inverse once released
    task automatic push(input logic [DATA_W-1:0] d);
        @(negedge i_clk_sys);
        o_host_byte = '{valid: 1'b1, data: d};
        @(negedge i_clk_sys);
        o_host_byte = '{valid: 1'b0, data: ~d};
    endtask
endmodule // host_model

/* sim/reader_power_mode_control_tb.sv */
// Self-checking bench for the reader power mode controller
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module reader_power_mode_control_tb
    import pwr_mode_pkg::*;
;
    logic clk, rst, w_strap, s_strap, is_tx;
    logic p_take, h_take, en, wk, cfg_wr, ck, oe, rdy, fld, dir, ser, full, empty;
    logic irq;
    logic [7:0] cfg_o;
    host_cfg_t hcfg;
    byte_t hb, rxb, fo;
    pwr_enables_t ens;
    int failures = 0, tests_run = 0, n, i, ones;
    host_cfg_t rows [5] = '{12'h45a, 12'h2a5, 12'h6ff, 12'h000, 12'h43c};
    host_model host_model_inst (.i_clk_sys(clk), .o_enable_pin(en), .o_wake_mode_pin(wk),
        .o_host_cfg(hcfg), .o_cfg_wr(cfg_wr), .o_host_byte(hb));
    reader_power_mode_control reader_power_mode_control_inst (.i_clk_sys(clk), .i_reset(rst),
        .i_enable_pin(en), .i_wake_mode_pin(wk), .i_wake_strap(w_strap),
        .i_serial_strap(s_strap), .i_host_cfg(hcfg), .i_cfg_wr(cfg_wr), .i_host_byte(hb),
        .i_host_is_tx(is_tx), .i_proto_take(p_take), .i_rx_byte(rxb), .i_host_take(h_take),
        .o_system_clock_output(ck), .o_clkout_oe(oe), .o_enables(ens), .o_ready(rdy),
        .o_field_on(fld), .o_direct_mode(dir), .o_serial_mode(ser), .o_cfg(cfg_o),
        .o_fifo_out(fo), .o_fifo_full(full), .o_fifo_empty(empty), .o_host_irq(irq));
    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Cycles until the clock output changes twice; second span returned
    task automatic half_period(output int hp);
        logic v;
        v = ck;
        for (int k = 0; k < 4000 && ck === v; k++) @(negedge clk);
        v = ck;
        hp = 0;
        for (int k = 0; k < 4000 && ck === v; k++) begin
            @(negedge clk);
            hp++;
        end
    endtask
    // Bounded wait for ready, count of cycles returned
    task automatic wait_ready(output int c);
        for (c = 0; c < 12000 && rdy !== 1'b1; c++) @(negedge clk);
    endtask
    // One pop from either side, byte checked within three cycles
    task automatic pop(input logic host_side, input logic [7:0] d);
        @(negedge clk);
        if (host_side) h_take = 1'b1;
        else p_take = 1'b1;
        for (int k = 0; k < 3 && fo.valid !== 1'b1; k++) begin
            @(negedge clk);
            h_take = 1'b0;
            p_take = 1'b0;
        end
        `CHK(fo.data, d)
        @(negedge clk);
        h_take = 1'b0;
        p_take = 1'b0;
    endtask
    // Counts and verdict
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (90000) @(posedge clk);
        failures++;
        summarize();
    end
    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial begin
        rst = 1'b1;
        w_strap = 1'b0;
        s_strap = 1'b0;
        is_tx = 1'b0;
        p_take = 1'b0;
        h_take = 1'b0;
        rxb = '0;
        repeat (12) @(negedge clk);
        `CHK(ens, pwr_enables_t'('0))
        `CHK({oe, rdy, empty}, 3'b001)
        `CHK(cfg_o, CFG_PRESET)
        rst = 1'b0;
        s_strap = 1'b1;
        repeat (2) @(negedge clk);
        `CHK(ser, 1'b1)
        host_model_inst.set_enable(1'b1);
        repeat (2) @(negedge clk);
        `CHK({ens.reg_on, ens.ref_on, ens.xosc_on, ens.rfosc_on, ens.pll_on}, 5'h1f)
        `CHK(rdy, 1'b0)
        wait_ready(n);
        `CHK(n > OSC_SETTLE_CYC - 5, 1'b1)
        half_period(n);
        `CHK(n, HALF_NORMAL)
        foreach (rows[r]) begin
            host_model_inst.write_cfg(rows[r]);
            `CHK({cfg_o, fld, dir}, {rows[r].cfg, rows[r].field_enable_bit, rows[r].direct_mode})
        end
        is_tx = 1'b1;
        for (i = 0; i < 25; i++) host_model_inst.push(8'h10 + i[7:0]);
        `CHK(full, 1'b1)
        for (i = 0; i < 24; i++) pop(1'b0, 8'h10 + i[7:0]);
        `CHK(empty, 1'b1)
        is_tx = 1'b0;
        rxb = '{valid: 1'b1, data: 8'hc3};
        @(negedge clk);
        rxb = '{valid: 1'b0, data: 8'h3c};
        repeat (2) @(negedge clk);
        `CHK(irq, 1'b1)
        pop(1'b1, 8'hc3);
        `CHK({irq, empty}, 2'b01)
        host_model_inst.write_cfg(12'h63c);
        is_tx = 1'b1;
        host_model_inst.push(8'h77);
        @(negedge clk);
        `CHK(empty, 1'b1)
        host_model_inst.write_cfg(12'hc3c);
        repeat (2) @(negedge clk);
        `CHK({ens.pll_on, ens.tx_on, ens.rx_on, ens.reg_low_power, ens.xosc_low_power}, 5'h03)
        `CHK(cfg_o, 8'h3c)
        host_model_inst.write_cfg(12'h43c);
        wait_ready(n);
        `CHK({rdy, ens.pll_on, cfg_o}, {2'b11, 8'h3c})
        `CHK({ens.tx_on, ens.rx_on}, 2'b11)
        host_model_inst.write_cfg(12'h53c);
        ones = 0;
        for (i = 0; i < 40; i++) begin
            @(negedge clk);
            ones += oe;
            if (oe === 1'b1) `CHK(ck, 1'b0)
        end
        `CHK(ones > 0, 1'b1)
        `CHK(ones < 40, 1'b1)
        host_model_inst.write_cfg(12'hc3c);
        host_model_inst.set_enable(1'b0);
        repeat (3) @(negedge clk);
        `CHK({ens, rdy}, 11'h000)
        `CHK(cfg_o, CFG_PRESET)
        w_strap = 1'b1;
        repeat (2) @(negedge clk);
        `CHK(ens.vdd_d_low_power, 1'b1)
        half_period(n);
        `CHK(n, HALF_LOW)
        w_strap = 1'b0;
        host_model_inst.wake_pulse();
        repeat (10) @(negedge clk);
        `CHK(ens.reg_on, 1'b1)
        repeat (OSC_SETTLE_CYC) @(negedge clk);
        half_period(n);
        `CHK(n, HALF_NORMAL)
        repeat (WAKE_WINDOW_CYC + 100) @(negedge clk);
        `CHK(ens.reg_on, 1'b0)
        host_model_inst.wake_pulse();
        repeat (OSC_SETTLE_CYC + 100) @(negedge clk);
        host_model_inst.set_enable(1'b1);
        repeat (WAKE_WINDOW_CYC + 100) @(negedge clk);
        `CHK(rdy, 1'b1)
        rst = 1'b1;
        repeat (2) @(negedge clk);
        `CHK({rdy, empty, cfg_o}, {2'b01, CFG_PRESET})
        rst = 1'b0;
        s_strap = 1'b0;
        repeat (2) @(negedge clk);
        `CHK({rdy, ens.pll_on}, 2'b01)
        `CHK(ser, 1'b0)
        summarize();
    end
endmodule // reader_power_mode_control_tb
